// File: hdl/strap_decoder_map.svh
// register offsets, field layouts and reset values of the strap decoder
// assumes a 32-bit apb slave with word-aligned registers
`ifndef STRAP_DECODER_MAP_SVH
`define STRAP_DECODER_MAP_SVH

`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_USER_RATE 12'h008
`define OFS_ADDR_MATCH 12'h00c

`define CTRL_TX_REQ_BIT 0
`define CTRL_RELOAD_BIT 1
`define FIXED_BAUD 20'd9600
`define USER_RATE_RESET 20'd9600
`define ID_MIN 6'h01
`define ID_MAX 6'h20
`define ID_BCAST 6'h00

`endif

// File: hdl/strap_decoder_pkg.sv
// types shared by the strap decoder
// assumes the map header supplies all numeric constants
package strap_decoder_pkg;
    typedef enum logic [1:0] {
        st_reset = 2'b00,
        st_sample = 2'b01,
        st_run = 2'b10
    } state_type;
endpackage

// File: hdl/unit_id_baud_strap_decoder.sv
// power-up strap decoder for the host serial port rate and unit identity
// assumes straps static and synchronous to pclk, apb master on pclk
//
// Contract
// RQ1 - sample rate switch at reset, user uses project
// RQ2 - fixed position forces 9600 baud
// RQ3 - support chains of 2 to 32 units
// RQ4 - chained units use rs-485 host mode
// RQ5 - all chained units share one rate
// RQ6 - each chained unit has distinct identity
// RQ7 - identity is inverted switches plus one
// RQ8 - identity decoded once, then held
// RQ9 - exactly one unit holds identity 1
// RQ10 - transmitter enabled only answering own identity
`timescale 1ns/100ps
`include "strap_decoder_map.svh"

module unit_id_baud_strap_decoder (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // straps, switch on reads 1
    input wire logic rate_switch_user,
    input wire logic identity_switch_msb,
    input wire logic [2:0] identity_switch_mid,
    input wire logic identity_switch_lsb,
    // host port link
    input wire logic rs485_mode,
    input wire logic rx_frame_valid,
    input wire logic [5:0] rx_frame_addr,
    output logic [19:0] host_baud,
    output logic [5:0] unit_id,
    output logic id_valid,
    output logic tx_enable
);

    strap_decoder_pkg::state_type state_q, state_d;
    logic rate_user_q;
    logic [5:0] id_q;
    logic [19:0] user_rate_q;
    logic [19:0] baud_q;
    logic tx_req_q;
    logic answering_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    function automatic logic [5:0] decode_id(input logic [4:0] sw);
        decode_id = {1'b0, ~sw} + `ID_MIN;
    endfunction

    wire [4:0] sw_bus = {identity_switch_msb, identity_switch_mid,
        identity_switch_lsb};
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire setup = psel && !penable;
    wire setup_rd = setup && !pwrite;
    wire hit_ctrl = (paddr == `OFS_CTRL);
    wire hit_status = (paddr == `OFS_STATUS);
    wire hit_rate = (paddr == `OFS_USER_RATE);
    wire hit_match = (paddr == `OFS_ADDR_MATCH);
    wire hit_any = hit_ctrl || hit_status || hit_rate || hit_match;
    wire sampling = (state_q == strap_decoder_pkg::st_sample);
    wire running = (state_q == strap_decoder_pkg::st_run);
    wire reload = wr && hit_ctrl && pwdata[`CTRL_RELOAD_BIT];
    // own frame opens an answer window, broadcast never answered
    wire addr_mine = rx_frame_valid && running && (rx_frame_addr == id_q)
        && (rx_frame_addr != `ID_BCAST); // see RQ3
    wire [19:0] baud_sel = rate_user_q ? user_rate_q : `FIXED_BAUD;
    wire clear_answer = !tx_req_q || (wr && hit_match) || !running;
    wire tx_next = answering_q && tx_req_q && rs485_mode && running;
    wire [31:0] ctrl_word = {30'h0, 1'b0, tx_req_q};
    wire [31:0] status_word = {3'h0, rs485_mode, answering_q,
        rate_user_q, baud_q, id_q};
    wire [31:0] rate_word = {12'h0, user_rate_q};
    wire [31:0] match_word = {31'h0, answering_q};
    logic [31:0] rd_mux;

    // read decode, unmapped reads give zero
    always_comb begin
        if (hit_ctrl) begin
            rd_mux = ctrl_word;
        end else if (hit_status) begin
            rd_mux = status_word;
        end else if (hit_rate) begin
            rd_mux = rate_word;
        end else if (hit_match) begin
            rd_mux = match_word;
        end else begin
            rd_mux = 32'h0;
        end
    end

    // power-up sequence: reset, sample straps, run
    always_comb begin
        case (state_q)
            strap_decoder_pkg::st_reset: state_d = strap_decoder_pkg::st_sample;
            strap_decoder_pkg::st_sample: state_d = strap_decoder_pkg::st_run;
            strap_decoder_pkg::st_run: state_d = reload ?
                strap_decoder_pkg::st_sample : strap_decoder_pkg::st_run;
            default: state_d = strap_decoder_pkg::st_reset;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= strap_decoder_pkg::st_reset;
        end else begin
            state_q <= state_d;
        end
    end

    // identity caught once after reset release only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            id_q <= `ID_MIN;
        end else if (sampling && !running && state_q != state_d
                && !id_valid) begin
            id_q <= decode_id(sw_bus); // see RQ7 see RQ8
        end
    end

    // valid flag rises once per reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            id_valid <= 1'b0;
        end else if (sampling) begin
            id_valid <= 1'b1; // see RQ8
        end
    end

    // rate switch read at reset and at a reload command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_user_q <= 1'b0;
        end else if (sampling) begin
            rate_user_q <= rate_switch_user; // see RQ1
        end
    end

    // active rate follows the switch caught at sampling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_q <= `FIXED_BAUD;
        end else if (running) begin
            baud_q <= baud_sel; // see RQ1 see RQ2
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_rate_q <= `USER_RATE_RESET;
        end else if (wr && hit_rate) begin
            user_rate_q <= pwdata[19:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_req_q <= 1'b0;
        end else if (wr && hit_ctrl) begin
            tx_req_q <= pwdata[`CTRL_TX_REQ_BIT];
        end
    end

    // answer window set by own frame, closed when software drops request, writes the match register or leaves run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            answering_q <= 1'b0;
        end else if (addr_mine) begin
            answering_q <= 1'b1; // see RQ10
        end else if (clear_answer) begin
            answering_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_enable <= 1'b0;
        end else begin
            tx_enable <= tx_next; // see RQ10 see RQ4
        end
    end

    // read data caught in the setup cycle, shown in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (setup_rd) begin
            prdata_q <= rd_mux;
        end
    end

    // unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= setup && !hit_any;
        end
    end

    // zero wait states, ready in every access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign host_baud = baud_q;
    assign unit_id = id_q;

endmodule

// File: tb/strap_decoder_asserts.sv
// port checks of the strap decoder
// assumes bind onto the decoder top
`timescale 1ns/100ps
module strap_decoder_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // straps and link
    input wire logic rate_switch_user,
    input wire logic identity_switch_msb,
    input wire logic [2:0] identity_switch_mid,
    input wire logic identity_switch_lsb,
    input wire logic rs485_mode,
    // decoded outputs
    input wire logic [19:0] host_baud,
    input wire logic [5:0] unit_id,
    input wire logic id_valid,
    input wire logic tx_enable
);
    wire logic [5:0] sw_id = {1'h0, ~{identity_switch_msb,
        identity_switch_mid, identity_switch_lsb}} + 6'h01;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_fixed_rate: assert property ($rose(id_valid)
        && !rate_switch_user |=> host_baud == 20'h02580)
        else $error("fixed rate not applied");
    a_id_decode: assert property ($rose(id_valid)
        |-> unit_id == sw_id) else $error("identity decode wrong");
    a_id_held: assert property (id_valid && $past(id_valid)
        |-> $stable(unit_id)) else $error("identity changed");
    a_id_range: assert property (id_valid
        |-> unit_id >= 6'h01 && unit_id <= 6'h20)
        else $error("identity out of range");
    a_tx_idle: assert property (!id_valid |-> !tx_enable)
        else $error("driver on before identity");
    a_tx_mode: assert property ($rose(tx_enable)
        |-> $past(rs485_mode)) else $error("driver on outside mode");
    c_answer: cover property ($rose(tx_enable));
    c_id_top: cover property (id_valid && unit_id == 6'h20);
    c_fixed: cover property ($rose(id_valid) && !rate_switch_user);
endmodule
bind unit_id_baud_strap_decoder strap_decoder_asserts u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .rate_switch_user(rate_switch_user),
    .identity_switch_msb(identity_switch_msb),
    .identity_switch_mid(identity_switch_mid),
    .identity_switch_lsb(identity_switch_lsb),
    .rs485_mode(rs485_mode),
    .host_baud(host_baud),
    .unit_id(unit_id),
    .id_valid(id_valid),
    .tx_enable(tx_enable)
);

// File: tb/chain_host_model.sv
// host end of the chain, sends addressed frames
// assumes calls just after a rising edge
`timescale 1ns/100ps
module chain_host_model (
    // clock
    input wire logic pclk,
    // frame out
    output logic rx_frame_valid,
    output logic [5:0] rx_frame_addr
);
    initial begin
        rx_frame_valid = 1'h0;
        rx_frame_addr = 6'h3f;
    end
    // one frame, address inverted when idle
    task automatic send(input logic [5:0] a);
        rx_frame_valid <= 1'h1;
        rx_frame_addr <= a;
        @(posedge pclk);
        rx_frame_valid <= 1'h0;
        rx_frame_addr <= ~a;
        @(posedge pclk);
    endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the strap decoder
// assumes the host model drives the frame inputs
`timescale 1ns/100ps
`include "strap_decoder_map.svh"
module testbench;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, rate_switch_user, identity_switch_msb;
    logic identity_switch_lsb, rs485_mode = 1'h1, pready, pslverr;
    logic rx_frame_valid, id_valid, tx_enable, er;
    logic [2:0] identity_switch_mid;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [5:0] rx_frame_addr, unit_id;
    logic [19:0] host_baud;
    // rate, switches on, identity, baud
    logic [31:0] rows [4] = '{32'h7c102580, 32'h8201c200,
        32'hf821c200, 32'h3d102580};
    int bad_count = 0, total_checks = 0;
    unit_id_baud_strap_decoder u_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rate_switch_user(rate_switch_user),
        .identity_switch_msb(identity_switch_msb),
        .identity_switch_mid(identity_switch_mid),
        .identity_switch_lsb(identity_switch_lsb),
        .rs485_mode(rs485_mode),
        .rx_frame_valid(rx_frame_valid),
        .rx_frame_addr(rx_frame_addr),
        .host_baud(host_baud),
        .unit_id(unit_id),
        .id_valid(id_valid),
        .tx_enable(tx_enable)
    );
    chain_host_model u_host (
        .pclk(pclk),
        .rx_frame_valid(rx_frame_valid),
        .rx_frame_addr(rx_frame_addr)
    );
    always #10 pclk = ~pclk;
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        logic ok;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 8) begin
            n++;
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        ok = (pready === 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
        if (!ok) begin
            bad_count++;
            stop_test();
        end
    endtask
    initial begin
        for (int i = 0; i < 4; i++) begin
            {rate_switch_user, identity_switch_msb, identity_switch_mid,
                identity_switch_lsb} <= rows[i][31:26];
            presetn <= 1'h0;
            repeat (8) @(posedge pclk);
            presetn <= 1'h1;
            repeat (4) @(posedge pclk);
            chk(32'(unit_id), 32'(rows[i][25:20]));
            apb(1'h1, `OFS_USER_RATE, 32'h1c200);
            apb(1'h1, `OFS_CTRL, 32'h2);
            repeat (3) @(posedge pclk);
            chk(32'(host_baud), 32'(rows[i][19:0]));
            $display("row %0d done", i);
        end
        {identity_switch_msb, identity_switch_mid} <= 4'h0;
        apb(1'h1, `OFS_CTRL, 32'h3);
        repeat (3) @(posedge pclk);
        chk(32'(unit_id), 32'h11);
        chk(32'(id_valid), 32'h1);
        apb(1'h0, 12'h010, 32'h0);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        $display("hold test done");
        u_host.send(6'h12);
        u_host.send(6'h00);
        repeat (2) @(posedge pclk);
        chk(32'(tx_enable), 32'h0);
        rs485_mode <= 1'h0;
        u_host.send(6'h11);
        repeat (3) @(posedge pclk);
        chk(32'(tx_enable), 32'h0);
        apb(1'h1, `OFS_ADDR_MATCH, 32'h0);
        rs485_mode <= 1'h1;
        repeat (3) @(posedge pclk);
        chk(32'(tx_enable), 32'h0);
        u_host.send(6'h11);
        repeat (3) @(posedge pclk);
        chk(32'(tx_enable), 32'h1);
        apb(1'h0, `OFS_STATUS, 32'h0);
        chk(rd, {3'h0, 1'h1, 1'h1, 1'h0, `FIXED_BAUD, 6'h11});
        apb(1'h1, `OFS_ADDR_MATCH, 32'h0);
        @(posedge pclk);
        chk(32'(tx_enable), 32'h0);
        $display("tx test done");
        presetn <= 1'h0;
        @(posedge pclk);
        chk(32'(id_valid), 32'h0);
        chk(32'(tx_enable), 32'h0);
        chk(32'(host_baud), 32'(`FIXED_BAUD));
        presetn <= 1'h1;
        repeat (4) @(posedge pclk);
        chk(32'(unit_id), 32'h1f);
        $display("reset test done");
        stop_test();
    end
endmodule
